// *** core/rtcp_pkg.sv ***
// Shared constants for the clock chip host port and interrupt logic.
package rtcp_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;
  localparam int NUM_REGS = 16;
  // ----------------------------------------
  // Register indices inside the device
  // ----------------------------------------
  localparam logic [3:0] IDX_ALARM_MIN_LO = 4'h0;
  localparam logic [3:0] IDX_ALARM_MIN_HI = 4'h1;
  localparam logic [3:0] IDX_ALARM_HR_LO = 4'h2;
  localparam logic [3:0] IDX_ALARM_HR_HI = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'hE;
  localparam logic [3:0] IDX_FLAGS = 4'hF;
  // ----------------------------------------
  // Bit positions in the control and flag registers
  // ----------------------------------------
  localparam int BIT_ALARM_EN = 0;
  localparam int BIT_PERIODIC_EN = 1;
  localparam int BIT_TIMER_EN = 2;
  localparam int BIT_ALARM_FLAG = 0;
  localparam int BIT_PERIODIC_FLAG = 1;
  localparam int BIT_OSC_HALT = 2;
  // ----------------------------------------
  // Reset values and host timing
  // ----------------------------------------
  localparam logic [3:0] RST_VAL = 4'h0;
  localparam int SETUP_NS = 8;
  localparam int CLK_NS = 4;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = 2;
  localparam logic [1:0] SETUP_CNT = 2'(SETUP_CYC);
  localparam logic [1:0] STROBE_CNT = 2'(STROBE_CYC);
endpackage

// *** core/rtcp_if.sv ***
// Parallel bus and open-drain outputs between host and clock device.
`timescale 1ns/1ps
`default_nettype none
interface rtcp_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [rtcp_pkg::ADDR_W-1:0] addr;
  logic [rtcp_pkg::DATA_W-1:0] wdata;
  logic [rtcp_pkg::DATA_W-1:0] rdata;
  logic rdata_oe;
  logic int_drive;
  logic timer_drive;
  logic interrupt_out_n;
  logic timer_out_n;
  // ----------------------------------------
  // Open-drain resolution with pull-ups
  // ----------------------------------------
  assign interrupt_out_n = ~int_drive;
  assign timer_out_n = ~timer_drive;
  modport device (input cs_n, input rd_n, input wr_n, input addr, input wdata,
    output rdata, output rdata_oe, output int_drive, output timer_drive);
  modport host (output cs_n, output rd_n, output wr_n, output addr, output wdata,
    input rdata, input rdata_oe, input interrupt_out_n, input timer_out_n);
endinterface
`default_nettype wire

// *** core/rtcp_device.sv ***
// Device end: register store, strobe decode, interrupt and timer pins.
`timescale 1ns/1ps
`default_nettype none
module rtcp_device (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic backup_n_i,
  input wire logic alarm_tick_i,
  input wire logic periodic_tick_i,
  input wire logic osc_halt_i,
  input wire logic timer_tick_i,
  input wire logic [7:0] time_hr_min_i,
  rtcp_if.device bus
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Events are applied last, so a host clear in the same cycle cannot lose one.
  function automatic logic flag_upd(input logic cur, input logic wr_hit, input logic wr_bit,
    input logic evt);
    logic val;
    val = cur;
    if (wr_hit) begin
      val = wr_bit;
    end
    if (evt) begin
      val = 1'b1;
    end
    return val;
  endfunction

  // The flag index is decoded on both the read path and the write path.
  function automatic logic is_flags(input logic [3:0] a);
    return a == rtcp_pkg::IDX_FLAGS;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [3:0] regs_reg [rtcp_pkg::NUM_REGS];
  logic [3:0] regs_next [rtcp_pkg::NUM_REGS];
  logic wr_prev_reg;
  logic wr_prev_next;
  logic rd_act_reg;
  logic rd_act_next;
  logic [3:0] rdata_reg;
  logic [3:0] rdata_next;
  logic alarm_flag_reg;
  logic alarm_flag_next;
  logic per_flag_reg;
  logic per_flag_next;
  logic halt_reg;
  logic halt_next;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_act;
  logic wr_end;
  logic rd_act;
  logic flags_wr;
  logic [3:0] flags_word;
  logic [3:0] ctrl_word;

  // Select may stay low; the strobes alone then frame each access.
  // The bus is ignored in backup, except that a write strobe still low as backup starts ends there and is stored.
  // Access start gating.
  assign wr_act = ~bus.cs_n & ~bus.wr_n & backup_n_i;
  assign rd_act = ~bus.cs_n & ~bus.rd_n & backup_n_i;
  // Storing on the rising strobe gives address and data the whole pulse to settle.
  // Write ends on strobe rise.
  assign wr_end = wr_prev_reg & ~wr_act;
  assign flags_wr = wr_end & is_flags(bus.addr);
  assign flags_word = {1'b0, halt_reg, per_flag_reg, alarm_flag_reg};
  assign ctrl_word = regs_reg[rtcp_pkg::IDX_CTRL];

  // ----------------------------------------
  // Alarm compare
  // ----------------------------------------
  logic alarm_hit;
  logic [7:0] alarm_cmp;

  // Only the low hour and low minute digits take part; longer periods are left to host software.
  // Low-digit match only; it can repeat within a day.
  assign alarm_cmp = {regs_reg[rtcp_pkg::IDX_ALARM_HR_LO],
    regs_reg[rtcp_pkg::IDX_ALARM_MIN_LO]};
  // The compare is sampled only on the minute tick, so a match raises the flag once.
  assign alarm_hit = alarm_tick_i & (alarm_cmp == time_hr_min_i);

  // ----------------------------------------
  // Strobe tracking
  // ----------------------------------------
  always_comb begin
    wr_prev_next = wr_act;
    rd_act_next = rd_act;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_prev_reg <= 1'b0;
      rd_act_reg <= 1'b0;
    end else if (clk_en_i) begin
      wr_prev_reg <= wr_prev_next;
      rd_act_reg <= rd_act_next;
    end
  end

  // ----------------------------------------
  // Register store
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < rtcp_pkg::NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    // No range or digit check exists; invalid digits are the host's to avoid.
    // Digits stored without checking.
    if (wr_end) begin
      regs_next[bus.addr] = bus.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < rtcp_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= rtcp_pkg::RST_VAL;
      end
    end else if (clk_en_i) begin
      regs_reg <= regs_next;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_act) begin
      rdata_next = regs_reg[bus.addr];
      if (is_flags(bus.addr)) begin
        rdata_next = flags_word;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= rtcp_pkg::RST_VAL;
    end else if (clk_en_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_comb begin
    alarm_flag_next = flag_upd(alarm_flag_reg, flags_wr,
      bus.wdata[rtcp_pkg::BIT_ALARM_FLAG], alarm_hit);
    per_flag_next = flag_upd(per_flag_reg, flags_wr,
      bus.wdata[rtcp_pkg::BIT_PERIODIC_FLAG], periodic_tick_i);
    halt_next = flag_upd(halt_reg, flags_wr,
      bus.wdata[rtcp_pkg::BIT_OSC_HALT], osc_halt_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      alarm_flag_reg <= 1'b0;
      per_flag_reg <= 1'b0;
      // Halt starts set so the timer pin stays released until the host clears it.
      halt_reg <= 1'b1;
    end else if (clk_en_i) begin
      alarm_flag_reg <= alarm_flag_next;
      per_flag_reg <= per_flag_next;
      halt_reg <= halt_next;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign bus.rdata = rdata_reg;
  // Read data is driven only from the second strobe cycle, once the register holds it.
  assign bus.rdata_oe = rd_act_reg & rd_act;
  // The line is a level, not a pulse, so it stays low until every enabled flag is cleared.
  // OR of both sources, independent of backup.
  // Alarm not gated by backup input.
  // Level held while enabled flag set.
  assign bus.int_drive =
    (alarm_flag_reg & ctrl_word[rtcp_pkg::BIT_ALARM_EN]) |
    (per_flag_reg & ctrl_word[rtcp_pkg::BIT_PERIODIC_EN]);
  // Halt is sticky, so a stopped oscillator keeps the timer pin off until the host clears it.
  // Halt flag turns timer pin off.
  assign bus.timer_drive = ~halt_reg & timer_tick_i &
    ctrl_word[rtcp_pkg::BIT_TIMER_EN];
endmodule
`default_nettype wire

// *** core/rtcp_host.sv ***
// Host end: sequences read and write strobes on the parallel bus.
`timescale 1ns/1ps
`default_nettype none
module rtcp_host (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic req_i,
  input wire logic req_wr_i,
  input wire logic [3:0] req_addr_i,
  input wire logic [3:0] req_wdata_i,
  input wire logic irq_mask_i,
  output logic busy_o,
  output logic done_o,
  output logic [3:0] rdata_o,
  output logic irq_o,
  output logic timer_o,
  rtcp_if.host bus
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_END} rtcp_state_e;
  rtcp_state_e st_reg, st_next;
  logic [1:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [3:0] addr_reg, addr_next, wd_reg, wd_next, rd_reg, rd_next;
  logic done_reg, done_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (req_i) begin
          wr_next = req_wr_i;
          addr_next = req_addr_i;
          wd_next = req_wdata_i;
          cnt_next = rtcp_pkg::SETUP_CNT;
          st_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == 2'h1) begin
          cnt_next = rtcp_pkg::STROBE_CNT;
          st_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == 2'h1) begin
          rd_next = bus.rdata;
          st_next = ST_END;
        end
      end
      ST_END: begin
        done_next = 1'b1;
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      wr_reg <= 1'b0;
      addr_reg <= 4'h0;
      wd_reg <= 4'h0;
      rd_reg <= 4'h0;
      done_reg <= 1'b0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
    end
  end

  // Select stays low permanently; strobes alone frame each access.
  assign bus.cs_n = 1'b0;
  assign bus.rd_n = ~((st_reg == ST_STROBE) & ~wr_reg);
  assign bus.wr_n = ~((st_reg == ST_STROBE) & wr_reg);
  assign bus.addr = addr_reg;
  assign bus.wdata = wd_reg;
  assign busy_o = (st_reg != ST_IDLE);
  assign done_o = done_reg;
  assign rdata_o = rd_reg;
  assign irq_o = ~bus.interrupt_out_n & ~irq_mask_i;
  assign timer_o = ~bus.timer_out_n;
endmodule
`default_nettype wire

// *** tb/rtcp_sva.sv ***
// Checker for the host bus strobes and open-drain pins.
`timescale 1ns/1ps
`default_nettype none
module rtcp_sva (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [rtcp_pkg::ADDR_W-1:0] addr_i,
  input wire logic rdata_oe_i,
  input wire logic int_drive_i,
  input wire logic timer_drive_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  strobe_excl_a: assert property (rd_n_i || wr_n_i)
    else $error("both strobes low");
  rd_pulse_a: assert property ($fell(rd_n_i) |-> ##1 !rd_n_i ##1 rd_n_i)
    else $error("read strobe length");
  wr_pulse_a: assert property ($fell(wr_n_i) |-> ##1 !wr_n_i ##1 wr_n_i)
    else $error("write strobe length");
  // An address moving under a strobe would hit the wrong register.
  addr_hold_a: assert property (!rd_n_i || !wr_n_i |-> $stable(addr_i) && !cs_n_i)
    else $error("address moved in access");
  oe_window_a: assert property (rdata_oe_i |-> !rd_n_i && !cs_n_i)
    else $error("read data driven outside read");
  oe_delay_a: assert property ($fell(rd_n_i) |-> !rdata_oe_i ##1 rdata_oe_i)
    else $error("read data enable timing");
  int_hold_a: assert property ($fell(int_drive_i) |-> !$past(wr_n_i) || !$past(wr_n_i, 2))
    else $error("interrupt released without write");
  timer_off_a: assert property ($rose(rst_n_i) |-> !timer_drive_i)
    else $error("timer pin driven after start");
endmodule
`default_nettype wire

// *** tb/rtcp_test.sv ***
// Self-checking bench joining the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module rtcp_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic backup_n = 1'b1, al_tick = 1'b0, per_tick = 1'b0, halt = 1'b0, tick = 1'b0;
  logic req = 1'b0, req_wr = 1'b0, mask = 1'b0;
  logic [7:0] hr_min = 8'h00;
  logic [3:0] req_addr = 4'h0, req_wdata = 4'h0, rdata;
  logic busy, done, irq, tmr;
  int error_cnt = 0;
  int checks = 0;
  rtcp_if bus ();
  always #2 ref_clk_i = ~ref_clk_i;
  rtcp_device i_rtcp_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .backup_n_i(backup_n), .alarm_tick_i(al_tick), .periodic_tick_i(per_tick),
    .osc_halt_i(halt), .timer_tick_i(tick), .time_hr_min_i(hr_min), .bus(bus.device));
  rtcp_host i_rtcp_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .req_i(req), .req_wr_i(req_wr), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .irq_mask_i(mask), .busy_o(busy), .done_o(done), .rdata_o(rdata), .irq_o(irq),
    .timer_o(tmr), .bus(bus.host));
  rtcp_sva i_rtcp_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(bus.cs_n),
    .rd_n_i(bus.rd_n), .wr_n_i(bus.wr_n), .addr_i(bus.addr), .rdata_oe_i(bus.rdata_oe),
    .int_drive_i(bus.int_drive), .timer_drive_i(bus.timer_drive));
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk_i);
    req = 1'b0;
    chk("busy", 4'(busy), 4'h1);
    while (done !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      summarize();
    end
    chk("latency", 4'(n), 4'(rtcp_pkg::SETUP_CYC + rtcp_pkg::STROBE_CYC + 1));
    @(negedge ref_clk_i);
    chk("done", 4'(done), 4'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    xfer(1'b0, a, 4'h0);
    chk("rdata", rdata, e);
  endtask
  task automatic pulse(input logic al, input logic pe);
    @(negedge ref_clk_i);
    al_tick = al;
    per_tick = pe;
    @(negedge ref_clk_i);
    al_tick = 1'b0;
    per_tick = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task automatic pin(input logic e);
    chk("pin", 4'(bus.interrupt_out_n), 4'(e));
  endtask
  task automatic t_reset();
    chk("timer", 4'(bus.timer_out_n), 4'h1);
    rd(rtcp_pkg::IDX_FLAGS, 4'h4);
  endtask
  task automatic t_store();
    xfer(1'b1, rtcp_pkg::IDX_ALARM_MIN_LO, 4'hF);
    rd(rtcp_pkg::IDX_ALARM_MIN_LO, 4'hF);
    xfer(1'b1, rtcp_pkg::IDX_ALARM_HR_HI, 4'hC);
    rd(rtcp_pkg::IDX_ALARM_HR_HI, 4'hC);
    xfer(1'b1, rtcp_pkg::IDX_ALARM_MIN_LO, 4'h0);
    xfer(1'b1, rtcp_pkg::IDX_ALARM_HR_HI, 4'h0);
  endtask
  task automatic t_or();
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h0);
    xfer(1'b1, rtcp_pkg::IDX_ALARM_MIN_LO, 4'h5);
    xfer(1'b1, rtcp_pkg::IDX_ALARM_HR_LO, 4'h7);
    xfer(1'b1, rtcp_pkg::IDX_CTRL, 4'h3);
    hr_min = 8'h65;
    pulse(1'b1, 1'b0);
    rd(rtcp_pkg::IDX_FLAGS, 4'h0);
    hr_min = 8'h75;
    pulse(1'b1, 1'b1);
    pin(1'b0);
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h1);
    pin(1'b0);
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h2);
    pin(1'b0);
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h0);
    pin(1'b1);
  endtask
  task automatic t_back();
    backup_n = 1'b0;
    pulse(1'b1, 1'b0);
    pin(1'b0);
    chk("irq", 4'(irq), 4'h1);
    mask = 1'b1;
    @(negedge ref_clk_i);
    chk("irq", 4'(irq), 4'h0);
    mask = 1'b0;
    backup_n = 1'b1;
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h0);
    pin(1'b1);
  endtask
  task automatic t_timer();
    xfer(1'b1, rtcp_pkg::IDX_CTRL, 4'h7);
    tick = 1'b1;
    @(negedge ref_clk_i);
    chk("timer", 4'(tmr), 4'h1);
    halt = 1'b1;
    @(negedge ref_clk_i);
    halt = 1'b0;
    @(negedge ref_clk_i);
    chk("timer", 4'(tmr), 4'h0);
    rd(rtcp_pkg::IDX_FLAGS, 4'h4);
    chk("timer", 4'(tmr), 4'h0);
    xfer(1'b1, rtcp_pkg::IDX_FLAGS, 4'h0);
    chk("timer", 4'(tmr), 4'h1);
    pin(1'b1);
    tick = 1'b0;
    @(negedge ref_clk_i);
    chk("timer", 4'(tmr), 4'h0);
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_store();
    t_or();
    t_back();
    t_timer();
    summarize();
  end
endmodule
`default_nettype wire
